// ### src/hss_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "hss_map.svh"
// Summary of operation
// RQ1: low deep sleep input enters standby from any state or mode.
// RQ2: standby halts cpu, stops supporting modules, floats all I/O ports.
// RQ3: entering standby resets every supporting-module register to initial values.
// RQ4: on-chip RAM is kept unchanged in standby; only state retained.
// RQ5: controller clears internal_memory_enable before pulling deep sleep low.
// RQ6: mode selects must stay stable throughout standby.
// RQ7: both mode selects low in standby means programmer mode; avoid.
// RQ8: exit needs deep sleep release then cold start release.
// RQ9: deep sleep going high restarts the clock oscillator.
// RQ10: cold start must be low at release and held through settling.
// RQ11: cold start rising after recovery runs reset sequence, then normal run.
// RQ12: entry order is cold start low, then deep sleep low.
// RQ13: exit order is deep sleep high, then cold start after settling.
// RQ14: low deep sleep forces standby asynchronously without a clock edge.
module hss_sequencer
    import hss_pkg::*;
#(
    parameter int SETTLE_CYCLES = `HSS_SETTLE_CYCLES,
    parameter int RESET_SEQ_CYCLES = `HSS_RESET_SEQ_CYCLES,
    parameter int PORT_WIDTH = `HSS_PORT_WIDTH
) (
    input wire logic i_clk, // 25 MHz clock
    input wire logic i_sys_rst, // sync reset, active high
    input wire logic i_ce, // clock enable
    input wire logic i_deep_sleep_in_n, // standby pin, active low
    input wire logic i_cold_start_in_n, // reset pin, active low
    input wire hss_mode_t i_mode, // mode select pins
    input wire logic [PORT_WIDTH-1:0] i_port_out, // port data from core
    input wire logic [PORT_WIDTH-1:0] i_port_oe, // port enables from core
    output hss_ctrl_t o_ctrl, // control to core and modules
    output logic [PORT_WIDTH-1:0] o_port_out, // port pin data
    output logic [PORT_WIDTH-1:0] o_port_oe, // port pin enables
    output logic o_programmer_mode, // both mode selects low in standby
    output logic o_mode_changed, // mode pins moved during standby
    output logic o_standby // in hardware standby
);
    localparam int CNT_W = $clog2(SETTLE_CYCLES + RESET_SEQ_CYCLES + 1);
    localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);
    localparam logic [CNT_W-1:0] RESET_LAST = CNT_W'(RESET_SEQ_CYCLES - 1);

    hss_state_t state;
    hss_state_t next_state;
    logic [CNT_W-1:0] cnt;
    logic sleep_sync;
    logic cold_sync;
    logic mode_hi_sync;
    logic mode_lo_sync;
    wire logic [1:0] mode_raw;
    wire logic [1:0] mode_sync;
    hss_mode_t mode_now;
    hss_mode_t mode_held;
    // async standby latch: clears only by the clock after the pin is back high
    logic deep_sleep_in_n_async;
    logic deep_sleep_in_n_meta;
    logic deep_sleep_in_n_seen;

    hss_sync3 #(.RESET_VAL(1'b1)) u_sync_sleep (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
        .i_async(i_deep_sleep_in_n), .o_level(sleep_sync)
    );
    hss_sync3 #(.RESET_VAL(1'b0)) u_sync_cold (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
        .i_async(i_cold_start_in_n), .o_level(cold_sync)
    );
    // both mode pins share one filter shape; bit 1 is the high select
    assign mode_raw = i_mode;
    for (genvar g = 0; g < 2; g++) begin : g_mode_sync
        hss_sync3 #(.RESET_VAL(1'b1)) u_sync_mode (
            .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
            .i_async(mode_raw[g]), .o_level(mode_sync[g])
        );
    end
    assign mode_hi_sync = mode_sync[1];
    assign mode_lo_sync = mode_sync[0];
    assign mode_now = '{mode_select_hi: mode_hi_sync, mode_select_lo: mode_lo_sync};

    // one decode for every output that stays parked outside run
    function automatic logic not_running(input hss_state_t s);
        return s != HSS_RUN;
    endfunction

    // pin low forces standby with no clock; constant load only
    always_ff @(posedge i_clk or negedge i_deep_sleep_in_n) begin
        if (!i_deep_sleep_in_n) begin
            deep_sleep_in_n_async <= 1'b1; // RQ14
        end else if (i_sys_rst) begin
            deep_sleep_in_n_async <= 1'b0;
        end else if (i_ce && state == HSS_OSC_START) begin
            deep_sleep_in_n_async <= 1'b0;
        end
    end

    // the latch is asynchronous to i_clk, so bring it in before the fsm looks
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            deep_sleep_in_n_meta <= 1'b0;
            deep_sleep_in_n_seen <= 1'b0;
        end else if (i_ce) begin
            deep_sleep_in_n_meta <= deep_sleep_in_n_async;
            deep_sleep_in_n_seen <= deep_sleep_in_n_meta;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            HSS_RUN: begin
                if (deep_sleep_in_n_seen || !sleep_sync) begin
                    next_state = HSS_STANDBY; // RQ1
                end
            end
            HSS_STANDBY: begin
                // only the filtered pin here; the raw latch is not on this clock
                // filter lags the latch, so one pass through osc start can occur while outputs stay forced
                if (sleep_sync) begin
                    next_state = HSS_OSC_START; // RQ9
                end
            end
            HSS_OSC_START: begin
                if (!sleep_sync) begin
                    next_state = HSS_STANDBY; // RQ1
                end else if (cnt == SETTLE_LAST) begin
                    next_state = HSS_WAIT_RELEASE; // RQ10
                end
            end
            HSS_WAIT_RELEASE: begin
                if (!sleep_sync) begin
                    next_state = HSS_STANDBY; // RQ1
                end else if (cold_sync) begin
                    next_state = HSS_RESET_SEQ; // RQ8 RQ11
                end
            end
            HSS_RESET_SEQ: begin
                if (!sleep_sync) begin
                    next_state = HSS_STANDBY; // RQ1
                end else if (cnt == RESET_LAST) begin
                    next_state = HSS_RUN; // RQ11
                end
            end
            default: next_state = HSS_STANDBY;
        endcase
    end

    // reset starts in standby-like hold so nothing runs before a clean sequence
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state <= HSS_STANDBY;
        end else if (i_ce) begin
            state <= next_state;
        end
    end

    // count restarts on any state change, so each wait starts from zero
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cnt <= '0;
        end else if (i_ce) begin
            if (next_state != state) begin
                cnt <= '0;
            end else if (state == HSS_OSC_START || state == HSS_RESET_SEQ) begin
                cnt <= cnt + CNT_W'(1);
            end
        end
    end

    // ports float while standby is forced, even with no clock running
    always_ff @(posedge i_clk or negedge i_deep_sleep_in_n) begin
        if (!i_deep_sleep_in_n) begin
            o_port_oe <= '0; // RQ2 RQ14
            o_port_out <= '0;
            o_ctrl <= '{cpu_halt: 1'b1, module_stop: 1'b1, module_reset: 1'b1,
                        ram_hold: 1'b1, osc_enable: 1'b0, port_float: 1'b1}; // RQ2 RQ3 RQ4
            o_standby <= 1'b1;
        end else if (i_sys_rst) begin
            o_port_oe <= '0;
            o_port_out <= '0;
            o_ctrl <= '{cpu_halt: 1'b1, module_stop: 1'b1, module_reset: 1'b1,
                        ram_hold: 1'b1, osc_enable: 1'b0, port_float: 1'b1};
            o_standby <= 1'b1;
        end else if (i_ce) begin
            o_standby <= (next_state == HSS_STANDBY);
            o_ctrl.cpu_halt <= not_running(next_state); // RQ2 RQ8
            o_ctrl.module_stop <= not_running(next_state); // RQ2
            o_ctrl.module_reset <= not_running(next_state); // RQ3 RQ11
            // ram contents are never touched; hold asserted outside run
            o_ctrl.ram_hold <= not_running(next_state); // RQ4
            o_ctrl.osc_enable <= (next_state != HSS_STANDBY); // RQ9
            o_ctrl.port_float <= not_running(next_state); // RQ2
            if (!not_running(next_state)) begin
                o_port_oe <= i_port_oe;
                o_port_out <= i_port_out;
            end else begin
                o_port_oe <= '0; // RQ2
                o_port_out <= '0;
            end
        end
    end

    // mode pins watched only while in standby; the device flags misuse
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            mode_held <= '{mode_select_hi: 1'b1, mode_select_lo: 1'b1};
            o_mode_changed <= 1'b0;
            o_programmer_mode <= 1'b0;
        end else if (i_ce) begin
            if (state != HSS_STANDBY) begin
                mode_held <= mode_now;
                o_mode_changed <= 1'b0;
                o_programmer_mode <= 1'b0;
            end else begin
                o_mode_changed <= o_mode_changed ||
                    (mode_held != mode_now); // RQ6
                o_programmer_mode <= !mode_hi_sync && !mode_lo_sync; // RQ7
            end
        end
    end
endmodule
`default_nettype wire

// ### src/hss_map.svh
`ifndef HSS_MAP_SVH
`define HSS_MAP_SVH
// oscillator settling count, cycles of i_clk after deep sleep release
`define HSS_SETTLE_CYCLES 8192
// cycles the supporting-module reset pulse is held after cold start release
`define HSS_RESET_SEQ_CYCLES 16
`define HSS_PORT_WIDTH 8
`endif

// ### src/hss_pkg.sv
package hss_pkg;
    typedef enum logic [2:0] {
        HSS_RUN,
        HSS_STANDBY,
        HSS_OSC_START,
        HSS_WAIT_RELEASE,
        HSS_RESET_SEQ
    } hss_state_t;

    typedef struct packed {
        logic cpu_halt;
        logic module_stop;
        logic module_reset;
        logic ram_hold;
        logic osc_enable;
        logic port_float;
    } hss_ctrl_t;

    typedef struct packed {
        logic mode_select_hi;
        logic mode_select_lo;
    } hss_mode_t;
endpackage

// ### src/hss_sync3.sv
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; the output moves only when stages two and three agree
module hss_sync3 #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic i_clk, // clock
    input wire logic i_sys_rst, // sync reset
    input wire logic i_ce, // clock enable
    input wire logic i_async, // raw pin
    output logic o_level // filtered level
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            s1 <= RESET_VAL;
            s2 <= RESET_VAL;
            s3 <= RESET_VAL;
        end else if (i_ce) begin
            s1 <= i_async;
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_level <= RESET_VAL;
        end else if (i_ce && (s2 == s3)) begin
            o_level <= s3;
        end
    end
endmodule
`default_nettype wire

// ### test/hss_sequencer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module hss_sequencer_assertions
    import hss_pkg::*;
#(
    parameter int SETTLE_CYCLES = 8192,
    parameter int RESET_SEQ_CYCLES = 16,
    parameter int PORT_WIDTH = 8
) (
    input wire logic i_clk, // clock
    input wire logic i_sys_rst, // reset
    input wire logic i_ce, // enable
    input wire logic i_deep_sleep_in_n, // standby pin
    input wire logic i_cold_start_in_n, // reset pin
    input wire hss_mode_t i_mode, // mode pins
    input wire logic [PORT_WIDTH-1:0] i_port_out, // core data
    input wire logic [PORT_WIDTH-1:0] i_port_oe, // core enables
    input wire hss_ctrl_t o_ctrl, // control
    input wire logic [PORT_WIDTH-1:0] o_port_out, // pin data
    input wire logic [PORT_WIDTH-1:0] o_port_oe, // pin enables
    input wire logic o_programmer_mode, // mode misuse
    input wire logic o_mode_changed, // mode moved
    input wire logic o_standby // standby
);
    // saturates so long settle counts cannot wrap into a false fail
    logic [15:0] wake_cnt;
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || !i_deep_sleep_in_n) begin
            wake_cnt <= 16'h0000;
        end else if (wake_cnt != 16'hffff) begin
            wake_cnt <= wake_cnt + 16'h0001;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    sleep_standby_a: assert property (
        !i_deep_sleep_in_n |-> o_standby && o_port_oe == '0
    ) else $error("no standby");
    standby_halt_a: assert property (
        o_standby |-> o_ctrl.cpu_halt && o_ctrl.module_stop && o_ctrl.port_float
    ) else $error("not halted");
    standby_reset_a: assert property (
        o_standby |-> o_ctrl.module_reset && o_port_oe == '0
    ) else $error("not reset");
    ram_hold_a: assert property (o_standby |-> o_ctrl.ram_hold) else $error("ram not held");
    osc_restart_a: assert property (
        $rose(i_deep_sleep_in_n) ##1 i_deep_sleep_in_n[*7] |-> o_ctrl.osc_enable
    ) else $error("no osc");
    settle_exit_a: assert property (
        $fell(o_ctrl.cpu_halt) |-> int'(wake_cnt) > SETTLE_CYCLES + RESET_SEQ_CYCLES
    ) else $error("early run");
    reset_seq_a: assert property (
        $fell(o_ctrl.cpu_halt) |-> $past(o_ctrl.module_reset) && $past(o_ctrl.osc_enable) && !$past(o_standby)
            && !o_ctrl.module_reset
    ) else $error("no reset seq");
    port_follow_a: assert property (
        !o_ctrl.cpu_halt && !$past(o_ctrl.cpu_halt) |->
            ($past(i_ce) && o_port_oe == $past(i_port_oe) && o_port_out == $past(i_port_out))
            || (!$past(i_ce) && $stable(o_port_oe) && $stable(o_port_out))
    ) else $error("port lag");
    cover property ($fell(o_standby));
    cover property ($fell(o_ctrl.cpu_halt));
    cover property (o_programmer_mode && o_mode_changed);
endmodule
bind hss_sequencer hss_sequencer_assertions #(
    .SETTLE_CYCLES(SETTLE_CYCLES), .RESET_SEQ_CYCLES(RESET_SEQ_CYCLES), .PORT_WIDTH(PORT_WIDTH)
) chk_u (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_deep_sleep_in_n(i_deep_sleep_in_n),
    .i_cold_start_in_n(i_cold_start_in_n), .i_mode(i_mode), .i_port_out(i_port_out), .i_port_oe(i_port_oe),
    .o_ctrl(o_ctrl), .o_port_out(o_port_out), .o_port_oe(o_port_oe), .o_programmer_mode(o_programmer_mode),
    .o_mode_changed(o_mode_changed), .o_standby(o_standby)
);
`default_nettype wire

// ### test/hss_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
module hss_supervisor
    import hss_pkg::*;
(
    input wire logic i_clk, // clock
    input wire logic i_sleep_req, // want standby
    input wire logic [7:0] i_hold, // reset hold after wake
    input wire logic i_misuse, // let mode pins move
    input wire hss_mode_t i_mode_req, // wanted mode
    output logic o_deep_sleep_in_n, // standby pin
    output logic o_cold_start_in_n, // reset pin
    output hss_mode_t o_mode // mode pins
);
    initial begin
        o_deep_sleep_in_n = 1'b1;
        o_cold_start_in_n = 1'b1;
        o_mode = 2'h3;
        forever begin
            @(negedge i_clk);
            if (i_sleep_req && o_deep_sleep_in_n) begin
                o_cold_start_in_n = 1'b0;
                @(negedge i_clk);
                o_deep_sleep_in_n = 1'b0;
            end else if (!i_sleep_req && !o_deep_sleep_in_n) begin
                o_deep_sleep_in_n = 1'b1;
                repeat (i_hold) @(negedge i_clk);
                o_cold_start_in_n = 1'b1;
            end
            if (o_deep_sleep_in_n || i_misuse) begin
                o_mode = i_mode_req;
            end
        end
    end
endmodule
`default_nettype wire

// ### test/hw_standby_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
module hw_standby_sequencer_test;
    import hss_pkg::*;
    localparam int SET = 8;
    localparam int RSQ = 2;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0;
    logic misuse = 1'b0;
    logic ce = 1'b1;
    logic [7:0] hold = 8'h14;
    hss_mode_t mode_req = 2'h3;
    logic [7:0] pout = 8'h00;
    logic [7:0] poe = 8'h00;
    logic dsn, csn, prog, mchg, deep_sleep_in_n;
    hss_mode_t mode;
    hss_ctrl_t ctrl;
    logic [7:0] qout, qoe;
    int err_count = 0;
    int total_checks = 0;
    int n;
    initial begin
        forever #20 clk = ~clk;
    end
    hss_supervisor sup_u (.i_clk(clk), .i_sleep_req(req), .i_hold(hold), .i_misuse(misuse), .i_mode_req(mode_req),
        .o_deep_sleep_in_n(dsn), .o_cold_start_in_n(csn), .o_mode(mode));
    hss_sequencer #(.SETTLE_CYCLES(SET), .RESET_SEQ_CYCLES(RSQ), .PORT_WIDTH(8)) dut_u (.i_clk(clk),
        .i_sys_rst(rst), .i_ce(ce), .i_deep_sleep_in_n(dsn), .i_cold_start_in_n(csn), .i_mode(mode),
        .i_port_out(pout), .i_port_oe(poe), .o_ctrl(ctrl), .o_port_out(qout), .o_port_oe(qoe),
        .o_programmer_mode(prog), .o_mode_changed(mchg), .o_standby(deep_sleep_in_n));
    task automatic end_of_test();
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s exp %h got %h", name, exp, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic wait_run();
        n = 0;
        while (ctrl.cpu_halt !== 1'b0) begin
            n++;
            if (n > 400) begin
                err_count++;
                end_of_test();
            end
            cyc(1);
        end
    endtask
    task automatic check_standby();
        check("standby", 8'h01, {7'h00, deep_sleep_in_n});
        check("port_oe", 8'h00, qoe);
        check("ctrl", 8'h3d, {2'h0, ctrl});
    endtask
    initial begin
        logic [7:0] holds [4];
        holds = '{8'h03, 8'h14, 8'h3c, 8'h14};
        void'($urandom(32'h90d3_4340));
        holds[1] = 8'($urandom_range(14, 40));
        cyc(8);
        check_standby();
        rst <= 1'b0;
        wait_run();
        check("ctrl_run", 8'h02, {2'h0, ctrl});
        for (int k = 0; k < 4; k++) begin
            for (int i = 0; i < 10; i++) begin
                pout <= 8'($urandom);
                poe <= 8'($urandom);
                cyc(1);
                check("port_out", pout, qout);
                check("port_oe", poe, qoe);
            end
            if (k == 1) begin
                ce <= 1'b0;
                pout <= ~pout;
                cyc(3);
                check("ce_hold", ~pout, qout);
                ce <= 1'b1;
                cyc(1);
                check("port_out", pout, qout);
            end
            req <= 1'b1;
            misuse <= (k == 3);
            cyc(2);
            #1 check("async", 8'h01, {7'h00, deep_sleep_in_n});
            cyc(4);
            check_standby();
            if (k == 3) begin
                mode_req <= 2'h0;
                cyc(8);
                check("prog", 8'h01, {7'h00, prog});
                check("mchg", 8'h01, {7'h00, mchg});
                mode_req <= 2'h3;
                cyc(8);
            end
            req <= 1'b0;
            hold <= holds[k];
            if (k == 2) begin
                cyc(30);
                check("halt", 8'h01, {7'h00, ctrl.cpu_halt});
                check("osc", 8'h01, {7'h00, ctrl.osc_enable});
                check("standby", 8'h00, {7'h00, deep_sleep_in_n});
            end
            wait_run();
            check("settle", 8'h01, {7'h00, n + (k == 2 ? 30 : 0) > SET + RSQ});
            check("mchg", 8'h00, {7'h00, mchg});
            check("ctrl_run", 8'h02, {2'h0, ctrl});
        end
        rst <= 1'b1;
        cyc(2);
        check_standby();
        end_of_test();
    end
endmodule
`default_nettype wire
